/* File: hw/lcer_config_regs.sv */
// Dimming/sample/power and EMI spread/step configuration registers.
// Assumes the serial engine and lampTick run on core_clk; pins are async.
//
// Function
// (R1) Software sets dimming range to the band holding the external clock.
// (R2) Internal dimming oscillator constant k is 1, 2, 4 or 8 by range.
// (R3) Feedback sampled every 4, 8, 16 or 32 lamp cycles by rate field.
// (R4) Software writes zero to reserved bits; they read back as zero.
// (R5) Power-down register bit and power-down pin are ORed.
// (R6) Power-down resets controller, clears faults, enters low power.
// (R7) Spread code sets +-1.5/3/6 percent; step field sets modulation rate.
// (R8) Without spread, step field selects +1..+4 or -1 percent offset.
// (R9) Step enable bit ORed with step pin applies the selected step.
// (R10) External dimming clock must lie between 22.5 Hz and 440 Hz.
// (R11) Shape bit picks triangular or pseudo-random modulation.
// (R12) Write-protect bit blocks user memory writes; reads unaffected.
`default_nettype none

module lcer_config_regs
    import lcer_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    input  wire logic [7:0]            regAddr,
    input  wire logic                  regWrEn,
    input  wire logic [7:0]            regWrData,
    input  wire logic                  regRdEn,
    output var  logic [7:0]            regRdData_r,
    input  wire logic                  powerdown_pin,
    input  wire logic                  step_invoke_pin,
    input  wire logic                  dim_source_sel,
    input  wire logic                  lampTick,
    input  wire logic                  umemWrReq,
    output var  logic                  umemWrEn_r,
    output var  lcer_pkg::lcer_dim_ctrl_s dimCtrl_r,
    output var  lcer_pkg::lcer_emi_ctrl_s emiCtrl_r,
    output var  logic [3:0]            dimK_r,
    output var  logic                  sampleStrobe_r,
    output var  logic                  ctrlReset_r,
    output var  logic                  faultClear_r,
    output var  logic                  lowPower_r,
    output var  logic [1:0]            spreadAmount_r,
    output var  logic signed [7:0]     modWave_r,
    output var  logic signed [7:0]     stepOffset_r
);
    import lcer_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] pinMeta_r;
    logic [1:0] pinSync_r;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pinMeta_r <= 2'h0;
            pinSync_r <= 2'h0;
        end else begin
            pinMeta_r <= {step_invoke_pin, powerdown_pin};
            pinSync_r <= pinMeta_r;
        end
    end

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    logic dimWr;
    logic emiWr;
    assign dimWr = regWrEn && (regAddr == `LCER_DIM_CTRL_ADDR);
    assign emiWr = regWrEn && (regAddr == `LCER_EMI_CTRL_ADDR);

    // Reserved bits are masked on write so they always read as zero
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            dimCtrl_r <= lcer_dim_ctrl_s'(`LCER_DIM_CTRL_RST);
            emiCtrl_r <= lcer_emi_ctrl_s'(`LCER_EMI_CTRL_RST);
        end else begin
            if (dimWr) begin
                dimCtrl_r <= lcer_dim_ctrl_s'(regWrData
                             & `LCER_DIM_CTRL_WMASK); // R4
            end
            if (emiWr) begin
                emiCtrl_r <= lcer_emi_ctrl_s'(regWrData
                             & `LCER_EMI_CTRL_WMASK); // R4
            end
        end
    end

    // Unmapped offsets read zero; data is valid the cycle after regRdEn
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            regRdData_r <= 8'h00;
        end else if (regRdEn) begin
            if (regAddr == `LCER_DIM_CTRL_ADDR) begin
                regRdData_r <= dimCtrl_r;
            end else if (regAddr == `LCER_EMI_CTRL_ADDR) begin
                regRdData_r <= emiCtrl_r;
            end else begin
                regRdData_r <= 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            umemWrEn_r <= 1'b0;
        end else begin
            umemWrEn_r <= umemWrReq
                          && !dimCtrl_r.user_mem_write_protect; // R12
        end
    end

    // ----------------------------------------------------------------
    // Power-down
    // ----------------------------------------------------------------
    logic      pdReq;
    lcer_pwr_e pwrState_r;
    assign pdReq = dimCtrl_r.powerdown_bit || pinSync_r[0]; // R5

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pwrState_r <= PWR_RUN;
        end else begin
            case (pwrState_r)
                PWR_RUN:  if (pdReq) pwrState_r <= PWR_DOWN;
                PWR_DOWN: if (!pdReq) pwrState_r <= PWR_RUN;
                default:  pwrState_r <= PWR_RUN;
            endcase
        end
    end

    // Registers themselves survive power-down, else it could not be left
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ctrlReset_r  <= 1'b0;
            faultClear_r <= 1'b0;
            lowPower_r   <= 1'b0;
        end else begin
            ctrlReset_r  <= pdReq; // R6
            faultClear_r <= pdReq; // R6
            lowPower_r   <= pdReq; // R6
        end
    end

    // ----------------------------------------------------------------
    // Dimming constant and feedback sampling
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            dimK_r <= 4'h0;
        end else begin
            // External source needs no constant; zero marks it unused
            dimK_r <= dim_source_sel ? 4'h0
                    : `LCER_DIM_K_BASE << dimCtrl_r.dim_range_sel; // R2
        end
    end

    logic [5:0] samplePeriod;
    logic [5:0] lampCnt_r;
    assign samplePeriod = `LCER_SAMPLE_BASE
                          << dimCtrl_r.feedback_rate_sel;

    // Restart on any dimming register write so a new rate never sees a stale count
    always_ff @(posedge core_clk) begin
        if (!resetn || pwrState_r == PWR_DOWN || dimWr) begin
            lampCnt_r      <= 6'h00;
            sampleStrobe_r <= 1'b0;
        end else begin
            sampleStrobe_r <= 1'b0;
            if (lampTick) begin
                if (lampCnt_r == samplePeriod - 6'h01) begin // R3
                    lampCnt_r      <= 6'h00;
                    sampleStrobe_r <= 1'b1;
                end else begin
                    lampCnt_r <= lampCnt_r + 6'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Spread-spectrum modulation and frequency step
    // ----------------------------------------------------------------
    logic       spreadOn;
    logic [1:0] modPre_r;
    logic       modEvent;
    logic [7:0] modStep;
    logic       waveUp_r;
    logic [7:0] lfsr_r;
    logic       stepOn;
    assign spreadOn = emiCtrl_r.spread_amount != 2'h0;
    assign stepOn   = emiCtrl_r.freq_step_enable || pinSync_r[1]; // R9

    // Rates above lamp frequency take bigger steps per lamp tick
    always_comb begin
        modStep  = 8'h01;
        modEvent = lampTick;
        case (emiCtrl_r.freq_step_sel) // R7
            3'h0: modStep = 8'h04;
            3'h1: modStep = 8'h02;
            3'h2: modStep = 8'h01;
            3'h3: modEvent = lampTick && modPre_r[0];
            default: modEvent = lampTick && (modPre_r == 2'h3);
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn || !spreadOn || pwrState_r == PWR_DOWN) begin
            modPre_r  <= 2'h0;
            modWave_r <= 8'sh00;
            waveUp_r  <= 1'b1;
            lfsr_r    <= `LCER_LFSR_SEED;
        end else begin
            if (lampTick) begin
                modPre_r <= modPre_r + 2'h1;
            end
            if (modEvent) begin
                if (emiCtrl_r.spread_shape_sel) begin // R11
                    lfsr_r <= {lfsr_r[6:0], ^(lfsr_r & `LCER_LFSR_TAPS)};
                    modWave_r <= $signed(lfsr_r) >>> 1;
                end else if (waveUp_r) begin // R11
                    modWave_r <= modWave_r + $signed(modStep);
                    if (modWave_r + $signed(modStep)
                        >= $signed(`LCER_WAVE_LIMIT)) begin
                        waveUp_r <= 1'b0;
                    end
                end else begin
                    modWave_r <= modWave_r - $signed(modStep);
                    if (modWave_r - $signed(modStep)
                        <= -$signed(`LCER_WAVE_LIMIT)) begin
                        waveUp_r <= 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            spreadAmount_r <= 2'h0;
            stepOffset_r   <= 8'sh00;
        end else begin
            spreadAmount_r <= emiCtrl_r.spread_amount; // R7
            stepOffset_r   <= 8'sh00;
            if (!spreadOn && stepOn) begin
                case (emiCtrl_r.freq_step_sel) // R8
                    3'h0: stepOffset_r <= `LCER_STEP_UP1;
                    3'h1: stepOffset_r <= `LCER_STEP_UP2;
                    3'h2: stepOffset_r <= `LCER_STEP_UP3;
                    3'h3: stepOffset_r <= `LCER_STEP_UP4;
                    default: stepOffset_r <= `LCER_STEP_DN1;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    logic [5:0] tickSeen_r;
    // A tick in the strobe cycle already counts towards the next period
    always_ff @(posedge core_clk) begin
        if (!resetn || dimWr || pwrState_r == PWR_DOWN) begin
            tickSeen_r <= 6'h00;
        end else if (lampTick) begin
            tickSeen_r <= sampleStrobe_r ? 6'h01 : tickSeen_r + 6'h01;
        end else if (sampleStrobe_r) begin
            tickSeen_r <= 6'h00;
        end
    end

    sequence pdRise;
        !pdReq ##1 pdReq;
    endsequence
    sequence pdSettled;
        lowPower_r && ctrlReset_r && faultClear_r;
    endsequence

    chk_pd_or_pin: assert property (pinSync_r[0] |=> lowPower_r) // R5
        else $error("pin power-down not seen");
    chk_pd_enter: assert property (pdRise |=> pdSettled) // R6
        else $error("power-down did not reset and clear");
    chk_pd_leave: assert property ( // R6
        $fell(pdReq) |=> !lowPower_r && !ctrlReset_r)
        else $error("power-down did not release");
    chk_sample_period: assert property ( // R3
        lampTick && !dimWr && pwrState_r == PWR_RUN
        && tickSeen_r == samplePeriod - 6'h01 |=> sampleStrobe_r)
        else $error("feedback sample period wrong");
    chk_dim_k_map: assert property ( // R2
        !dim_source_sel ##1 !$changed(dimCtrl_r)
        |-> dimK_r == (`LCER_DIM_K_BASE << dimCtrl_r.dim_range_sel))
        else $error("dimming constant wrong");
    chk_rsvd_zero: assert property ( // R4
        dimCtrl_r.rsvd == 2'h0 && !emiCtrl_r.rsvd)
        else $error("reserved bit set");
    chk_step_apply: assert property ( // R8
        !spreadOn && stepOn && emiCtrl_r.freq_step_sel == 3'h4
        |=> stepOffset_r == 8'shF6)
        else $error("step down offset wrong");
    chk_step_idle: assert property ( // R9
        !stepOn || spreadOn |=> stepOffset_r == 8'sh00)
        else $error("step applied without request");
    chk_spread_off: assert property ( // R7
        !spreadOn |=> modWave_r == 8'sh00)
        else $error("modulation while spread disabled");
    chk_tri_bound: assert property ( // R11
        spreadOn && !emiCtrl_r.spread_shape_sel
        |-> modWave_r <= 8'sh44 && modWave_r >= -8'sh44)
        else $error("triangle out of range");
    chk_umem_gate: assert property ( // R12
        umemWrReq && dimCtrl_r.user_mem_write_protect |=> !umemWrEn_r)
        else $error("protected user memory written");

endmodule : lcer_config_regs

`default_nettype wire

/* File: hw/lcer_defs.svh */
// Offsets, write masks, reset values and table values of the lamp configuration regs.
// Assumes inclusion by the package and the testbench only.
`ifndef LCER_DEFS_SVH
`define LCER_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define LCER_DIM_CTRL_ADDR   8'hF5
`define LCER_EMI_CTRL_ADDR   8'hF6
`define LCER_DIM_CTRL_RST    8'h08
`define LCER_EMI_CTRL_RST    8'h00
`define LCER_DIM_CTRL_WMASK  8'h9F
`define LCER_EMI_CTRL_WMASK  8'hF7

// ----------------------------------------------------------------
// Counts and table values
// ----------------------------------------------------------------
`define LCER_SAMPLE_BASE     6'h04
`define LCER_DIM_K_BASE      4'h1
`define LCER_WAVE_LIMIT      8'h40
`define LCER_STEP_UP1        8'h0A
`define LCER_STEP_UP2        8'h14
`define LCER_STEP_UP3        8'h1E
`define LCER_STEP_UP4        8'h28
`define LCER_STEP_DN1        8'hF6
`define LCER_LFSR_SEED       8'h5A
`define LCER_LFSR_TAPS       8'hB8

`endif

/* File: hw/lcer_pkg.sv */
// Types shared by the lamp configuration register bank.
// Assumes lcer_defs.svh is on the include path.
`default_nettype none

package lcer_pkg;
    `include "lcer_defs.svh"

    // Dimming, sample rate and power control register layout
    typedef struct packed {
        logic       powerdown_bit;
        logic [1:0] rsvd;
        logic [1:0] feedback_rate_sel;
        logic [1:0] dim_range_sel;
        logic       user_mem_write_protect;
    } lcer_dim_ctrl_s;

    // Spread and step control register layout
    typedef struct packed {
        logic [2:0] freq_step_sel;
        logic       freq_step_enable;
        logic       rsvd;
        logic       spread_shape_sel;
        logic [1:0] spread_amount;
    } lcer_emi_ctrl_s;

    typedef enum logic {PWR_RUN, PWR_DOWN} lcer_pwr_e;
endpackage : lcer_pkg

`default_nettype wire

/* File: tb/test_lamp_ctrl_emi_config_regs.sv */
// Self-checking bench for the lamp configuration register bank.
// Assumes lcer_pkg is compiled first and hw/ is on the include path.
`default_nettype none
`include "lcer_defs.svh"
`define CHK(nm, e, g) begin \
    samplesChecked++; \
    if ((g) !== (e)) begin \
        nFail++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
    end \
end

module test_lamp_ctrl_emi_config_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import lcer_pkg::*;

    logic              core_clk = 1'b0;
    logic              resetn;
    logic [7:0]        regAddr;
    logic              regWrEn;
    logic [7:0]        regWrData;
    logic              regRdEn;
    logic [7:0]        regRdData;
    logic              powerdownPin;
    logic              stepInvokePin;
    logic              dimSourceSel;
    logic              lampTick;
    logic              umemWrReq;
    logic              umemWrEn;
    lcer_dim_ctrl_s    dimCtrl;
    lcer_emi_ctrl_s    emiCtrl;
    logic [3:0]        dimK;
    logic              sampleStrobe;
    logic              ctrlReset;
    logic              faultClear;
    logic              lowPower;
    logic [1:0]        spreadAmount;
    logic signed [7:0] modWave;
    logic signed [7:0] stepOffset;
    int                nFail = 0;
    int                samplesChecked = 0;

    lcer_config_regs i_lcer_config_regs (
        .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData_r(regRdData), .powerdown_pin(powerdownPin),
        .step_invoke_pin(stepInvokePin), .dim_source_sel(dimSourceSel),
        .lampTick(lampTick), .umemWrReq(umemWrReq),
        .umemWrEn_r(umemWrEn), .dimCtrl_r(dimCtrl), .emiCtrl_r(emiCtrl),
        .dimK_r(dimK), .sampleStrobe_r(sampleStrobe),
        .ctrlReset_r(ctrlReset), .faultClear_r(faultClear),
        .lowPower_r(lowPower), .spreadAmount_r(spreadAmount),
        .modWave_r(modWave), .stepOffset_r(stepOffset)
    );

    always #12.5 core_clk = ~core_clk;

    // ----------------------------------------------------------------
    // Bus tasks: inputs move 1 ns after the rising edge
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        tick(1);
        regWrEn = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regAddr = a;
        regRdEn = 1'b1;
        tick(1);
        regRdEn = 1'b0;
        `CHK("regRdData", e, regRdData)
    endtask : rd

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge core_clk);
        nFail++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic [7:0] mag;
        int         k;
        {resetn, regWrEn, regRdEn, powerdownPin, stepInvokePin} = '0;
        {dimSourceSel, lampTick, umemWrReq} = '0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        void'($urandom(32'h371d));
        tick(2);
        resetn = 1'b1;
        tick(1);
        `CHK("dimCtrl", 8'h08, dimCtrl)
        `CHK("emiCtrl", 8'h00, emiCtrl)
        `CHK("dimK", 4'h1, dimK)
        // Random contents with reserved bits forced high on write
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            wr(`LCER_DIM_CTRL_ADDR, (d & 8'h7F) | 8'h60);
            `CHK("dimCtrl", d & 8'h1F, dimCtrl)
            // An idle edge between strobes of the same kind
            tick(1);
            wr(`LCER_EMI_CTRL_ADDR, d | 8'h08);
            `CHK("emiCtrl", d & 8'hF7, emiCtrl)
            tick(1);
            wr(8'hF7, ~d);
            rd(8'hF7, 8'h00);
            tick(1);
            rd(`LCER_DIM_CTRL_ADDR, d & 8'h1F);
            tick(1);
            rd(`LCER_EMI_CTRL_ADDR, d & 8'hF7);
        end
        wr(`LCER_EMI_CTRL_ADDR, 8'h00);
        tick(1);
        for (int r = 0; r < 4; r++) begin
            wr(`LCER_DIM_CTRL_ADDR, 8'(r << 1));
            tick(1);
            `CHK("dimK", 4'(1 << r), dimK)
        end
        // External dimming clock: range set to the band that holds it
        dimSourceSel = 1'b1;
        wr(`LCER_DIM_CTRL_ADDR, 8'h02);
        tick(2);
        `CHK("dimK", 4'h0, dimK)
        `CHK("dimRange", 2'h1, dimCtrl.dim_range_sel)
        dimSourceSel = 1'b0;
        // Ticks every cycle: strobe count equals the sample period
        for (int r = 0; r < 4; r++) begin
            wr(`LCER_DIM_CTRL_ADDR, 8'(r << 3));
            lampTick = 1'b1;
            k = 0;
            do begin
                tick(1);
                k++;
            end while (sampleStrobe !== 1'b1 && k < 40);
            `CHK("samplePeriod", 8'(4 << r), 8'(k))
            tick(1);
            `CHK("sampleStrobe", 1'b0, sampleStrobe)
            lampTick = 1'b0;
        end
        powerdownPin = 1'b1;
        tick(2);
        `CHK("lowPower", 1'b0, lowPower)
        tick(1);
        `CHK("pdOuts", 3'b111, {ctrlReset, faultClear, lowPower})
        powerdownPin = 1'b0;
        tick(3);
        `CHK("pdOuts", 3'b000, {ctrlReset, faultClear, lowPower})
        wr(`LCER_DIM_CTRL_ADDR, 8'h80);
        `CHK("lowPower", 1'b0, lowPower)
        tick(1);
        `CHK("pdOuts", 3'b111, {ctrlReset, faultClear, lowPower})
        wr(`LCER_DIM_CTRL_ADDR, 8'h00);
        tick(2);
        `CHK("pdOuts", 3'b000, {ctrlReset, faultClear, lowPower})
        // Step codes via the enable bit, then via the pin
        for (int c = 0; c < 5; c++) begin
            d = (c < 4) ? 8'(10 * (c + 1)) : 8'hF6;
            wr(`LCER_EMI_CTRL_ADDR, 8'(c << 5));
            tick(1);
            `CHK("stepOffset", 8'h00, stepOffset)
            wr(`LCER_EMI_CTRL_ADDR, 8'(c << 5) | 8'h10);
            tick(1);
            `CHK("stepOffset", d, stepOffset)
            wr(`LCER_EMI_CTRL_ADDR, 8'(c << 5));
            stepInvokePin = 1'b1;
            tick(2);
            `CHK("stepOffset", 8'h00, stepOffset)
            tick(1);
            `CHK("stepOffset", d, stepOffset)
            stepInvokePin = 1'b0;
            tick(3);
        end
        // Modulation depth after 8 ticks from rest, triangle shape; last pass random shape
        for (int c = 0; c < 6; c++) begin
            wr(`LCER_EMI_CTRL_ADDR, 8'h00);
            tick(1);
            `CHK("modWave", 8'h00, modWave)
            d = (c < 5) ? 8'(c << 5) | 8'h10 | 8'(c % 3 + 1) : 8'h05;
            wr(`LCER_EMI_CTRL_ADDR, d);
            lampTick = 1'b1;
            tick(8);
            lampTick = 1'b0;
            tick(2);
            mag = modWave[7] ? 8'(-modWave) : 8'(modWave);
            `CHK("spreadAmount", d[1:0], spreadAmount)
            `CHK("stepOffset", 8'h00, stepOffset)
            if (c < 5) `CHK("modDepth", 8'(32 >> c), mag)
            else `CHK("shapeRandom", 1'b1, mag !== 8'd32)
        end
        // Write protect gates user-memory writes
        for (int p = 0; p < 2; p++) begin
            wr(`LCER_DIM_CTRL_ADDR, 8'(p));
            umemWrReq = 1'b1;
            tick(1);
            umemWrReq = 1'b0;
            `CHK("umemWrEn", 1'(p == 0), umemWrEn)
            tick(1);
            `CHK("umemWrEn", 1'b0, umemWrEn)
        end
        print_verdict();
    end
endmodule : test_lamp_ctrl_emi_config_regs
`default_nettype wire
